// [adcc_consts.svh]
/*
  Constants of the channel calibration register bank: register
  indices, field positions and reset values.
  Assumes it is included by bare name and holds definitions only.
*/
// How it works
// - Offset upper register holds bits 23:8.
// - Offset lower register bits 15:8 hold 7:0.
// - Gain upper register holds unsigned bits 23:8.
// - Gain lower register bits 15:8 hold 7:0.
// - Lower registers' low byte reads zero.
// - Gain upper resets 8000h, others 0000h.
// - Config bits 15:6 are signed phase delay.
// - Config bits 5:3 always read zero.
// - Config bit 2 disables channel DC block.
// - Config bits 1:0 select channel input.
// - Registers decoded at indices 1Eh through 24h.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// Register indices; byte address is four times the index.
`define ADCC_IDX_C4_OFS_HI  6'h1e
`define ADCC_IDX_C4_OFS_LO  6'h1f
`define ADCC_IDX_C4_GAIN_HI 6'h20
`define ADCC_IDX_C4_GAIN_LO 6'h21
`define ADCC_IDX_C5_CFG     6'h22
`define ADCC_IDX_C5_OFS_HI  6'h23
`define ADCC_IDX_C5_OFS_LO  6'h24

// Reset values.
`define ADCC_GAIN_HI_RST    16'h8000
`define ADCC_ZERO_RST       16'h0000

// Field positions.
`define ADCC_LOW_FIELD_MSB  15
`define ADCC_LOW_FIELD_LSB  8
`define ADCC_PHASE_MSB      15
`define ADCC_PHASE_LSB      6
`define ADCC_RESV_MSB       5
`define ADCC_RESV_LSB       3
`define ADCC_DCOFF_BIT      2
`define ADCC_MUX_MSB        1
`define ADCC_MUX_LSB        0

`endif

// [adcc_pkg.sv]
/*
  Types shared by the calibration register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcc_pkg;
  // Channel input selection codes.
  typedef enum logic [1:0] {
    ADCC_MUX_PINS    = 2'b00,
    ADCC_MUX_SHORTED = 2'b01,
    ADCC_MUX_POS_DC  = 2'b10,
    ADCC_MUX_NEG_DC  = 2'b11
  } adcc_mux_t;
  // One 24-bit calibration word.
  typedef logic [23:0] adcc_cal_t;
endpackage

// [adcc_pair_if.sv]
/*
  Carrier between the register bank and one calibration pair.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcc_pair_if;
  logic        wr_hi;  // Write strobe, upper register.
  logic        wr_lo;  // Write strobe, lower register.
  logic [1:0]  strb;   // Byte lanes of the write.
  logic [15:0] wdata;  // Write data.
  logic [23:0] value;  // Assembled calibration word.
  modport ctrl (output wr_hi, wr_lo, strb, wdata, input value);
  modport pair (input wr_hi, wr_lo, strb, wdata, output value);
endinterface
`default_nettype wire

// [adcc_cal_pair.sv]
/*
  One upper/lower calibration register pair.
  Assumes write strobes are single-cycle APB access pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_cal_pair #(
  parameter logic [15:0] HI_RST = `ADCC_ZERO_RST  // Upper reset.
) (
  input  wire logic    i_ref_clk,  // Clock.
  input  wire logic    i_rst,      // Async reset, high.
  adcc_pair_if.pair    bus         // Strobes and value.
);
  import adcc_pkg::*;

  logic [15:0] hi;  // Value bits 23:8.
  logic [7:0]  lo;  // Value bits 7:0.

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hi <= HI_RST;
    end else if (bus.wr_hi) begin
      if (bus.strb[0]) begin
        hi[7:0] <= bus.wdata[7:0];
      end
      if (bus.strb[1]) begin
        hi[15:8] <= bus.wdata[15:8];
      end
    end
  end

  // calibration lower byte.
  // The low byte is stored from wdata bits 15:8 when lane 1 is written.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lo <= 8'h00;
    end else if (bus.wr_lo && bus.strb[1]) begin
      lo <= bus.wdata[`ADCC_LOW_FIELD_MSB:`ADCC_LOW_FIELD_LSB];
    end
  end

  assign bus.value = {hi, lo};
endmodule
`default_nettype wire

// [adcc_cal_regs.sv]
/*
  Calibration and configuration register bank for channel 4
  offset and gain and channel 5 configuration and offset, as an
  APB slave with zero wait states.
  Assumes an APB master on the same clock and a datapath that
  consumes the registered calibration outputs.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_cal_regs (
  input  wire logic         i_ref_clk,   // 125 MHz clock.
  input  wire logic         i_rst,       // Async reset, high.
  input  wire logic         i_psel,      // APB select.
  input  wire logic         i_penable,   // APB enable.
  input  wire logic         i_pwrite,    // APB direction.
  input  wire logic [7:0]   i_paddr,     // APB byte address.
  input  wire logic [31:0]  i_pwdata,    // APB write data.
  input  wire logic [3:0]   i_pstrb,     // APB byte lanes.
  output logic [31:0]       o_prdata,    // APB read data.
  output logic              o_pready,    // APB ready.
  output logic              o_pslverr,   // APB error.
  input  wire logic [3:0]   i_global_dc_block_setting,  // Global.
  output adcc_pkg::adcc_cal_t o_chan4_offset,  // Ch4 offset.
  output adcc_pkg::adcc_cal_t o_chan4_gain,    // Ch4 gain.
  output adcc_pkg::adcc_cal_t o_chan5_offset,  // Ch5 offset.
  output logic [9:0]        o_chan5_phase_delay,  // Ch5 phase.
  output logic              o_chan5_dc_block_off, // Ch5 DC off.
  output logic              o_chan5_dc_block_en,  // Ch5 DC on.
  output adcc_pkg::adcc_mux_t o_chan5_input_select  // Ch5 mux.
);
  import adcc_pkg::*;

  // Byte addresses of the registers.
  localparam logic [7:0] A_C4OH = {`ADCC_IDX_C4_OFS_HI, 2'b00};
  localparam logic [7:0] A_C4OL = {`ADCC_IDX_C4_OFS_LO, 2'b00};
  localparam logic [7:0] A_C4GH = {`ADCC_IDX_C4_GAIN_HI, 2'b00};
  localparam logic [7:0] A_C4GL = {`ADCC_IDX_C4_GAIN_LO, 2'b00};
  localparam logic [7:0] A_C5CF = {`ADCC_IDX_C5_CFG, 2'b00};
  localparam logic [7:0] A_C5OH = {`ADCC_IDX_C5_OFS_HI, 2'b00};
  localparam logic [7:0] A_C5OL = {`ADCC_IDX_C5_OFS_LO, 2'b00};

  // Address decode flags.
  logic sel_c4oh;  // Ch4 offset upper.
  logic sel_c4ol;  // Ch4 offset lower.
  logic sel_c4gh;  // Ch4 gain upper.
  logic sel_c4gl;  // Ch4 gain lower.
  logic sel_c5cf;  // Ch5 config.
  logic sel_c5oh;  // Ch5 offset upper.
  logic sel_c5ol;  // Ch5 offset lower.
  logic hit;       // Any mapped register.

  // Transfer phases.
  logic setup;     // Setup cycle.
  logic acc_wr;    // Write access cycle.

  // Config register fields.
  logic [9:0] phase;       // Phase delay.
  logic       dc_off;      // DC block disable.
  adcc_mux_t  mux_sel;     // Input selection.

  // Read path.
  logic [15:0] next_rdata; // Selected read word.
  logic [15:0] rdata;      // Captured read word.
  logic        err;        // Captured error.

  // Carriers to the three calibration pairs.
  adcc_pair_if c4_ofs ();
  adcc_pair_if c4_gain ();
  adcc_pair_if c5_ofs ();

  // register decode.
  // Decoding the full byte address also rejects misaligned ones.
  always_comb begin
    sel_c4oh = (i_paddr == A_C4OH);
    sel_c4ol = (i_paddr == A_C4OL);
    sel_c4gh = (i_paddr == A_C4GH);
    sel_c4gl = (i_paddr == A_C4GL);
    sel_c5cf = (i_paddr == A_C5CF);
    sel_c5oh = (i_paddr == A_C5OH);
    sel_c5ol = (i_paddr == A_C5OL);
    hit = sel_c4oh | sel_c4ol | sel_c4gh | sel_c4gl |
          sel_c5cf | sel_c5oh | sel_c5ol;
  end

  // Phase qualifiers of the APB transfer.
  assign setup  = i_psel & ~i_penable;
  assign acc_wr = i_psel & i_penable & i_pwrite & hit;

  // The slave never inserts wait states.
  assign o_pready = i_psel & i_penable;

  // Fan the access write out to the calibration pairs.
  always_comb begin
    c4_ofs.wr_hi  = acc_wr & sel_c4oh;
    c4_ofs.wr_lo  = acc_wr & sel_c4ol;
    c4_ofs.strb   = i_pstrb[1:0];
    c4_ofs.wdata  = i_pwdata[15:0];
    c4_gain.wr_hi = acc_wr & sel_c4gh;
    c4_gain.wr_lo = acc_wr & sel_c4gl;
    c4_gain.strb  = i_pstrb[1:0];
    c4_gain.wdata = i_pwdata[15:0];
    c5_ofs.wr_hi  = acc_wr & sel_c5oh;
    c5_ofs.wr_lo  = acc_wr & sel_c5ol;
    c5_ofs.strb   = i_pstrb[1:0];
    c5_ofs.wdata  = i_pwdata[15:0];
  end

  adcc_cal_pair #(
    .HI_RST (`ADCC_ZERO_RST)
  ) u_c4_ofs (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (c4_ofs.pair)
  );

  adcc_cal_pair #(
    .HI_RST (`ADCC_GAIN_HI_RST)
  ) u_c4_gain (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (c4_gain.pair)
  );

  // Channel 5 offset pair.
  adcc_cal_pair #(
    .HI_RST (`ADCC_ZERO_RST)
  ) u_c5_ofs (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (c5_ofs.pair)
  );

  // words to the datapath.
  // The pairs' values are flops already, so no extra stage.
  assign o_chan4_offset = c4_ofs.value;
  assign o_chan4_gain   = c4_gain.value;
  assign o_chan5_offset = c5_ofs.value;

  // phase delay field.
  // Low lane carries bits 7:6, high lane bits 15:8.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 10'h000;
    end else if (acc_wr && sel_c5cf) begin
      if (i_pstrb[0]) begin
        phase[1:0] <= i_pwdata[7:6];
      end
      if (i_pstrb[1]) begin
        phase[9:2] <= i_pwdata[15:8];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dc_off <= 1'b0;
    end else if (acc_wr && sel_c5cf && i_pstrb[0]) begin
      dc_off <= i_pwdata[`ADCC_DCOFF_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mux_sel <= ADCC_MUX_PINS;
    end else if (acc_wr && sel_c5cf && i_pstrb[0]) begin
      mux_sel <= adcc_mux_t'(i_pwdata[`ADCC_MUX_MSB:`ADCC_MUX_LSB]);
    end
  end

  // effective filter enable.
  // The channel follows the global setting unless disabled here;
  // any nonzero global code counts as the filter being on.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan5_dc_block_en <= 1'b0;
    end else begin
      o_chan5_dc_block_en <= (|i_global_dc_block_setting) & ~dc_off;
    end
  end

  // Configuration fields straight from their flops.
  assign o_chan5_phase_delay  = phase;
  assign o_chan5_dc_block_off = dc_off;
  assign o_chan5_input_select = mux_sel;

  // lower registers read low byte zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (sel_c4oh) begin
      next_rdata = c4_ofs.value[23:8];
    end else if (sel_c4ol) begin
      next_rdata = {c4_ofs.value[7:0], 8'h00};
    end else if (sel_c4gh) begin
      next_rdata = c4_gain.value[23:8];
    end else if (sel_c4gl) begin
      next_rdata = {c4_gain.value[7:0], 8'h00};
    end else if (sel_c5cf) begin
      next_rdata = {phase, 3'b000, dc_off, mux_sel};
    end else if (sel_c5oh) begin
      next_rdata = c5_ofs.value[23:8];
    end else if (sel_c5ol) begin
      next_rdata = {c5_ofs.value[7:0], 8'h00};
    end
  end

  // Read data is caught in the setup cycle and stands until the
  // next setup, so the access phase needs no wait state.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 16'h0000;
    end else if (setup) begin
      rdata <= i_pwrite ? 16'h0000 : next_rdata;
    end
  end

  // unmapped address error.
  // Writes there are dropped; the error flags the transfer.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      err <= 1'b0;
    end else if (setup) begin
      err <= ~hit;
    end
  end

  // Upper half of the bus always reads zero.
  assign o_prdata  = {16'h0000, rdata};
  assign o_pslverr = err & o_pready;

  // Helper: high in the first cycle after reset release.
  logic first_cyc;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // A full-width write access to one register.
  sequence s_wr(logic [7:0] a);
    i_psel && i_penable && i_pwrite && i_paddr == a &&
    i_pstrb[1:0] == 2'b11;
  endsequence

  // A read transfer: setup at the address, then an access cycle.
  sequence s_rd(logic [7:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a
    ##1 i_psel && i_penable;
  endsequence

  property p_ofs_hi;
    s_wr(A_C4OH) |=> o_chan4_offset[23:8] == $past(i_pwdata[15:0]);
  endproperty
  a_ofs_hi: assert property (p_ofs_hi)
    else $error("ch4 offset upper write lost");

  property p_ofs_lo;
    s_wr(A_C4OL) |=> o_chan4_offset[7:0] == $past(i_pwdata[15:8]);
  endproperty
  a_ofs_lo: assert property (p_ofs_lo)
    else $error("ch4 offset lower write lost");

  property p_gain_hi;
    s_wr(A_C4GH) |=> o_chan4_gain[23:8] == $past(i_pwdata[15:0]);
  endproperty
  a_gain_hi: assert property (p_gain_hi)
    else $error("ch4 gain upper write lost");

  property p_gain_lo;
    s_wr(A_C4GL) |=> o_chan4_gain[7:0] == $past(i_pwdata[15:8]);
  endproperty
  a_gain_lo: assert property (p_gain_lo)
    else $error("ch4 gain lower write lost");

  property p_resv_lo;
    s_rd(A_C4GL) |-> o_prdata[7:0] == 8'h00 && !o_pslverr;
  endproperty
  a_resv_lo: assert property (p_resv_lo)
    else $error("lower register low byte not zero");

  property p_reset_vals;
    first_cyc |-> o_chan4_gain == 24'h80_0000 &&
      o_chan4_offset == 24'h00_0000 && o_chan5_phase_delay == 10'h000;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong reset value");

  property p_phase;
    s_wr(A_C5CF) |=> o_chan5_phase_delay == $past(i_pwdata[15:6]);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase delay write lost");

  property p_cfg_resv;
    s_rd(A_C5CF) |-> o_prdata[5:3] == 3'b000 &&
      o_prdata[15:6] == o_chan5_phase_delay;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv)
    else $error("config readback wrong");

  property p_dc_off;
    o_chan5_dc_block_off |=> !o_chan5_dc_block_en;
  endproperty
  a_dc_off: assert property (p_dc_off)
    else $error("DC block left on while disabled");

  property p_dc_follow;
    !o_chan5_dc_block_off && (|i_global_dc_block_setting) |=>
      o_chan5_dc_block_en;
  endproperty
  a_dc_follow: assert property (p_dc_follow)
    else $error("DC block not following global setting");

  property p_mux;
    s_wr(A_C5CF) |=> o_chan5_input_select == $past(i_pwdata[1:0]);
  endproperty
  a_mux: assert property (p_mux)
    else $error("input select write lost");

  property p_unmapped;
    i_psel && !i_penable && !hit ##1 i_penable |-> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  property p_mapped_ok;
    i_psel && !i_penable && hit ##1 i_penable |-> !o_pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access flagged as error");

  property p_assemble;
    s_rd(A_C5OH) |-> o_prdata[15:0] == o_chan5_offset[23:8];
  endproperty
  a_assemble: assert property (p_assemble)
    else $error("offset word and register disagree");
endmodule
`default_nettype wire

// [tb_top.sv]
/*
  Self-checking bench for the calibration register bank: APB access,
  reset values, field masks, byte lanes, unmapped places, outputs.
  Assumes the bank and its constants header compile alongside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module tb_top;
  import adcc_pkg::*;
  logic               i_ref_clk;   // Bench clock, 8 ns period.
  logic               i_rst;       // Asynchronous reset, high.
  logic               i_psel;      // APB select.
  logic               i_penable;   // APB enable.
  logic               i_pwrite;    // APB direction.
  logic [7:0]         i_paddr;     // APB byte address.
  logic [31:0]        i_pwdata;    // APB write data.
  logic [3:0]         i_pstrb;     // APB byte lanes.
  logic [3:0]         i_glob;      // Global filter code.
  logic [31:0]        o_prdata;    // Read data.
  logic               o_pready;    // Ready.
  logic               o_pslverr;   // Error.
  adcc_cal_t          o_c4o;       // Channel 4 offset word.
  adcc_cal_t          o_c4g;       // Channel 4 gain word.
  adcc_cal_t          o_c5o;       // Channel 5 offset word.
  logic [9:0]         o_phase;     // Channel 5 phase delay.
  logic               o_dcoff;     // Channel 5 filter disable.
  logic               o_dcen;      // Channel 5 filter enable.
  adcc_mux_t          o_mux;       // Channel 5 input select.
  int                 err_total;   // Mismatches seen.
  int                 n_checks;    // Comparisons made.
  logic [5:0]         idx [7] = '{`ADCC_IDX_C4_OFS_HI, `ADCC_IDX_C4_OFS_LO,
    `ADCC_IDX_C4_GAIN_HI, `ADCC_IDX_C4_GAIN_LO, `ADCC_IDX_C5_CFG,
    `ADCC_IDX_C5_OFS_HI, `ADCC_IDX_C5_OFS_LO};
  // Writable bits of each register, in map order.
  logic [15:0]        msk [7] = '{16'hffff, 16'hff00, 16'hffff, 16'hff00,
    16'hffc7, 16'hffff, 16'hff00};
  // Reset value of each register, in map order.
  logic [15:0]        rstv [7] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  adcc_cal_regs dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_global_dc_block_setting(i_glob), .o_chan4_offset(o_c4o),
    .o_chan4_gain(o_c4g), .o_chan5_offset(o_c5o),
    .o_chan5_phase_delay(o_phase), .o_chan5_dc_block_off(o_dcoff),
    .o_chan5_dc_block_en(o_dcen), .o_chan5_input_select(o_mux)
  );

  // Free-running clock at 125 MHz.
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value seen against the value expected.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for ready is bounded so a hang ends the run.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Writes one register by index with the given lanes.
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, {i, 2'b00}, {16'h0000, d}, s, rd, e);
    check({31'h0, e}, 32'h0000_0000);
  endtask

  // Reads one byte address and compares data and error.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic ee);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, 4'h0, rd, e);
    check(rd, {16'h0000, exp});
    check({31'h0, e}, {31'h0, ee});
  endtask

  // Lets the output flops and the one-cycle filter enable settle.
  task automatic settle();
    @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    #1;
  endtask

  // Every register and output holds its reset value.
  task automatic t_reset();
    for (int k = 0; k < 7; k++) begin
      rd_chk({idx[k], 2'b00}, rstv[k], 1'b0);
    end
    check({8'h0, o_c4g}, 32'h0080_0000);
    check({8'h0, o_c4o}, 32'h0000_0000);
    check({8'h0, o_c5o}, 32'h0000_0000);
    check({20'h0, o_phase, o_dcoff, o_dcen}, 32'h0000_0000);
    check({30'h0, o_mux}, 32'h0000_0000);
  endtask

  // All ones, then a pattern: reserved bits read zero, words assemble.
  task automatic t_fields();
    for (int k = 0; k < 7; k++) wr(idx[k], 16'hffff, 4'h3);
    for (int k = 0; k < 7; k++) begin
      rd_chk({idx[k], 2'b00}, msk[k], 1'b0);
    end
    for (int k = 0; k < 7; k++) wr(idx[k], 16'(16'h1234 + k * 16'h1111), 4'h3);
    settle();
    check({8'h0, o_c4o}, 32'h0012_3423);
    check({8'h0, o_c4g}, 32'h0034_5645);
    check({8'h0, o_c5o}, 32'h0067_8978);
    rd_chk({idx[1], 2'b00}, 16'h2300, 1'b0);
  endtask

  // Each input code, a negative phase boundary and the filter disable.
  task automatic t_config();
    for (int m = 0; m < 4; m++) begin
      i_glob <= (m == 0) ? 4'h0 : 4'h2;
      wr(idx[4], {10'h200, 3'b111, m[0], m[1:0]}, 4'h3);
      settle();
      check({22'h0, o_phase}, 32'h0000_0200);
      check({30'h0, o_mux}, m);
      check({31'h0, o_dcoff}, {31'h0, m[0]});
      check({31'h0, o_dcen}, {31'h0, (m != 0) && !m[0]});
      rd_chk({idx[4], 2'b00}, {10'h200, 3'b000, m[0], m[1:0]}, 1'b0);
    end
  endtask

  // Byte lanes: low lane only, upper lanes alone change nothing.
  task automatic t_lanes();
    wr(idx[5], 16'h0000, 4'h3);
    wr(idx[5], 16'hbeef, 4'h1);
    rd_chk({idx[5], 2'b00}, 16'h00ef, 1'b0);
    wr(idx[5], 16'hffff, 4'hc);
    rd_chk({idx[5], 2'b00}, 16'h00ef, 1'b0);
  endtask

  // Neighbouring, misaligned and far places are refused and read zero.
  task automatic t_unmapped();
    logic [31:0] rd;
    logic        e;
    logic [7:0]  bad [4] = '{8'h74, 8'h94, 8'h79, 8'hfc};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, bad[k], 32'h0000_ffff, 4'hf, rd, e);
      check({31'h0, e}, 32'h0000_0001);
      rd_chk(bad[k], 16'h0000, 1'b1);
    end
    rd_chk({idx[5], 2'b00}, 16'h00ef, 1'b0);
  endtask

  // A reset in mid-run brings every register back.
  task automatic t_rerun();
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    // The global code goes back to off so the filter enable reads zero.
    i_glob <= 4'h0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
  endtask

  // Main sequence; inputs have values from time zero.
  initial begin
    err_total = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    i_pstrb = 4'h0;
    i_glob = 4'h0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_fields();
    t_config();
    t_lanes();
    t_unmapped();
    t_rerun();
    test_done();
  end
endmodule
`default_nettype wire
